/* hw/rtcal_consts.vh */
// constants for the real-time clock, calendar, alarm and timer block
//======================================================================
// Function
// - sixteen byte registers; word pointer advances after every data byte.
// - answer bus address byte A3h for reads and A2h for writes.
// - control and status registers sit at words 00h and 01h.
// - seconds through years counters sit at words 02h to 08h.
// - alarm settings sit at words 09h to 0Ch.
// - clock output control 0Dh, timer control 0Eh, timer value 0Fh.
// - time, calendar and alarm fields are kept in BCD.
// - counters freeze while a read transfer is in progress.
// - an alarm field takes part only when its top bit is zero.
// - the alarm condition sets the alarm flag, which may drive the interrupt.
// - the alarm flag stays set until software clears it.
// - timer source is 4096, 64, 1 or 1/60 Hz; timer can be disabled.
// - the timer counts down from an 8-bit binary value software loads.
// - each countdown end sets the timer flag; only software clears it.
// - pulse-select picks timer interrupt as pulse per period or flag level.
// - reading the timer value returns the live countdown value.
// - square wave out at 32.768 kHz, 1024, 32 or 1 Hz; 32.768 kHz default.
// - square wave enabled after reset; when disabled the pin is released.
// - stopped oscillator holds internal reset of bus logic and registers.
// - supply low sets a flag in seconds; it stays until software clears it.
// - interrupt output is open-drain and active low.
`ifndef RTCAL_CONSTS_VH
`define RTCAL_CONSTS_VH

//======================================================================
// bus addresses
`define RTCAL_DEV_WR 8'hA2
`define RTCAL_DEV_RD 8'hA3

//======================================================================
// word addresses
`define RTCAL_A_CS1 4'h0
`define RTCAL_A_CS2 4'h1
`define RTCAL_A_SEC 4'h2
`define RTCAL_A_MIN 4'h3
`define RTCAL_A_HOUR 4'h4
`define RTCAL_A_DAY 4'h5
`define RTCAL_A_WDAY 4'h6
`define RTCAL_A_MON 4'h7
`define RTCAL_A_YEAR 4'h8
`define RTCAL_A_ALM0 4'h9
`define RTCAL_A_ALM3 4'hC
`define RTCAL_A_CLK 4'hD
`define RTCAL_A_TCTL 4'hE
`define RTCAL_A_TVAL 4'hF

//======================================================================
// field positions
`define RTCAL_CS1_MASK 8'hA8
`define RTCAL_CS1_STOP 5
`define RTCAL_CS2_TIP 4
`define RTCAL_CS2_ALM_FLAG 3
`define RTCAL_CS2_TMR_FLAG 2
`define RTCAL_CS2_AIE 1
`define RTCAL_CS2_TIE 0
`define RTCAL_TOP 7

//======================================================================
// reset values
`define RTCAL_RST_CS1 8'h00
`define RTCAL_RST_CS2 5'h00
`define RTCAL_RST_SEC 7'h00
`define RTCAL_RST_LOW_FLAG 1'b1
`define RTCAL_RST_ALM 8'h80
`define RTCAL_RST_CLK 3'h4
`define RTCAL_RST_TCTL 3'h3
`define RTCAL_RST_DAY 6'h01
`define RTCAL_RST_MON 5'h01

//======================================================================
// timing
`define RTCAL_CORE_CLK_NS 4
`define RTCAL_OSC_STOP_NS 100000
`define RTCAL_OSC_STOP_CYC (`RTCAL_OSC_STOP_NS / `RTCAL_CORE_CLK_NS)

`endif

/* hw/rtcal_i2c_slave.v */
// serial bus slave with auto-incrementing word pointer
`timescale 1ns/10ps
`default_nettype none
`include "rtcal_consts.vh"

module rtcal_i2c_slave (
	// clock and reset
	input wire core_clk_i,
	input wire rst_i,
	// bus pins
	input wire scl_i,
	input wire sda_i,
	output wire sda_o,
	output wire sda_oe_o,
	// register side
	input wire [7:0] rd_data_i,
	output wire [3:0] ptr_o,
	output wire [7:0] wr_data_o,
	output wire wr_stb_o,
	output wire rd_busy_o
);

//======================================================================
// states
localparam S_IDLE = 3'd0;
localparam S_RX = 3'd1;
localparam S_ACK = 3'd2;
localparam S_TX = 3'd3;
localparam S_RACK = 3'd4;
localparam R_DEV = 2'd0;
localparam R_WORD = 2'd1;
localparam R_DATA = 2'd2;

reg [1:0] scl_sy_ff;
reg [1:0] sda_sy_ff;
reg scl_d_ff;
reg sda_d_ff;
reg [2:0] state_ff;
reg [1:0] role_ff;
reg [3:0] cnt_ff;
reg [7:0] sh_ff;
reg [3:0] ptr_ff;
reg sda_oe_ff;
reg wr_stb_ff;
reg rd_ff;

wire scl_s = scl_sy_ff[1];
wire sda_s = sda_sy_ff[1];
wire scl_rise = scl_s & ~scl_d_ff;
wire scl_fall = ~scl_s & scl_d_ff;
wire bus_start = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
wire bus_stop = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

//======================================================================
// protocol engine
always @(posedge core_clk_i or posedge rst_i) begin
	if (rst_i) begin
		scl_sy_ff <= 2'h3;
		sda_sy_ff <= 2'h3;
		scl_d_ff <= 1'b1;
		sda_d_ff <= 1'b1;
		state_ff <= S_IDLE;
		role_ff <= R_DEV;
		cnt_ff <= 4'h0;
		sh_ff <= 8'h00;
		ptr_ff <= 4'h0;
		sda_oe_ff <= 1'b0;
		wr_stb_ff <= 1'b0;
		rd_ff <= 1'b0;
	end else begin
		scl_sy_ff <= {scl_sy_ff[0], scl_i};
		sda_sy_ff <= {sda_sy_ff[0], sda_i};
		scl_d_ff <= scl_s;
		sda_d_ff <= sda_s;
		wr_stb_ff <= 1'b0;
		if (wr_stb_ff)
			ptr_ff <= ptr_ff + 4'h1;
		if (bus_start) begin
			state_ff <= S_RX;
			role_ff <= R_DEV;
			cnt_ff <= 4'h0;
			sda_oe_ff <= 1'b0;
			rd_ff <= 1'b0;
		end else if (bus_stop) begin
			state_ff <= S_IDLE;
			sda_oe_ff <= 1'b0;
			rd_ff <= 1'b0;
		end else begin
			case (state_ff)
			S_RX: begin
				if (scl_rise && cnt_ff != 4'h8) begin
					sh_ff <= {sh_ff[6:0], sda_s};
					cnt_ff <= cnt_ff + 4'h1;
				end else if (scl_fall && cnt_ff == 4'h8) begin
					cnt_ff <= 4'h0;
					case (role_ff)
					R_DEV: begin
						if (sh_ff == `RTCAL_DEV_WR) begin
							sda_oe_ff <= 1'b1;
							state_ff <= S_ACK;
							role_ff <= R_WORD;
						end else if (sh_ff == `RTCAL_DEV_RD) begin
							sda_oe_ff <= 1'b1;
							state_ff <= S_ACK;
							rd_ff <= 1'b1;
						end else begin
							state_ff <= S_IDLE;
						end
					end
					R_WORD: begin
						ptr_ff <= sh_ff[3:0];
						sda_oe_ff <= 1'b1;
						state_ff <= S_ACK;
						role_ff <= R_DATA;
					end
					default: begin
						wr_stb_ff <= 1'b1;
						sda_oe_ff <= 1'b1;
						state_ff <= S_ACK;
					end
					endcase
				end
			end
			S_ACK: begin
				if (scl_fall) begin
					cnt_ff <= 4'h0;
					if (rd_ff) begin
						state_ff <= S_TX;
						sh_ff <= rd_data_i;
						sda_oe_ff <= ~rd_data_i[7];
					end else begin
						state_ff <= S_RX;
						sda_oe_ff <= 1'b0;
					end
				end
			end
			S_TX: begin
				if (scl_fall) begin
					if (cnt_ff == 4'h7) begin
						sda_oe_ff <= 1'b0;
						state_ff <= S_RACK;
						ptr_ff <= ptr_ff + 4'h1;
					end else begin
						sh_ff <= {sh_ff[6:0], 1'b0};
						sda_oe_ff <= ~sh_ff[6];
						cnt_ff <= cnt_ff + 4'h1;
					end
				end
			end
			S_RACK: begin
				if (scl_rise)
					state_ff <= sda_s ? S_IDLE : S_ACK;
			end
			default: begin
				state_ff <= S_IDLE;
			end
			endcase
		end
	end
end

assign sda_o = 1'b0;
assign sda_oe_o = sda_oe_ff;
assign ptr_o = ptr_ff;
assign wr_data_o = sh_ff;
assign wr_stb_o = wr_stb_ff;
assign rd_busy_o = rd_ff;

endmodule // rtcal_i2c_slave
`default_nettype wire

/* hw/rtcal_top.v */
// real-time clock, calendar, alarm, countdown timer and square wave output
`timescale 1ns/10ps
`default_nettype none
`include "rtcal_consts.vh"

module rtcal_top #(
	parameter [19:0] OSC_STOP_CYC = `RTCAL_OSC_STOP_CYC
) (
	// clock and reset
	input wire core_clk_i,
	input wire rst_i,
	// oscillator and supply monitor
	input wire osc_i,
	input wire supply_low_i,
	// serial bus
	input wire scl_i,
	input wire sda_i,
	output wire sda_o,
	output wire sda_oe_o,
	// interrupt, open drain
	output wire int_n_o,
	output wire int_n_oe_o,
	// square wave, open drain
	output wire square_wave_out_o,
	output wire square_wave_out_oe_o
);

//======================================================================
// functions
function [7:0] bcd_inc;
	input [7:0] v;
	begin
		if (v[3:0] == 4'h9)
			bcd_inc = {v[7:4] + 4'h1, 4'h0};
		else
			bcd_inc = {v[7:4], v[3:0] + 4'h1};
	end
endfunction

function [7:0] month_days;
	input [4:0] mon;
	input [7:0] yr;
	reg leap;
	begin
		leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6) :
			(yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
		case (mon)
		5'h02: month_days = leap ? 8'h29 : 8'h28;
		5'h04, 5'h06, 5'h09, 5'h11: month_days = 8'h30;
		default: month_days = 8'h31;
		endcase
	end
endfunction

//======================================================================
// oscillator watch and internal reset
reg [1:0] osc_sy_ff;
reg osc_d_ff;
reg [19:0] osc_idle_ff;
reg osc_rst_ff;
wire osc_s = osc_sy_ff[1];
wire osc_rise = osc_s & ~osc_d_ff;

always @(posedge core_clk_i or posedge rst_i) begin
	if (rst_i) begin
		osc_sy_ff <= 2'h0;
		osc_d_ff <= 1'b0;
		osc_idle_ff <= 20'h00000;
		osc_rst_ff <= 1'b1;
	end else begin
		osc_sy_ff <= {osc_sy_ff[0], osc_i};
		osc_d_ff <= osc_s;
		if (osc_rise) begin
			osc_idle_ff <= 20'h00000;
			osc_rst_ff <= 1'b0;
		end else if (osc_idle_ff >= OSC_STOP_CYC) begin
			osc_rst_ff <= 1'b1;
		end else begin
			osc_idle_ff <= osc_idle_ff + 20'h00001;
		end
	end
end

wire irst = rst_i | osc_rst_ff;

//======================================================================
// bus slave
wire [3:0] ptr;
wire [7:0] wr_data;
wire wr_stb;
wire rd_busy;
reg [7:0] rd_data;

rtcal_i2c_slave u_slave (
	.core_clk_i(core_clk_i),
	.rst_i(irst),
	.scl_i(scl_i),
	.sda_i(sda_i),
	.sda_o(sda_o),
	.sda_oe_o(sda_oe_o),
	.rd_data_i(rd_data),
	.ptr_o(ptr),
	.wr_data_o(wr_data),
	.wr_stb_o(wr_stb),
	.rd_busy_o(rd_busy)
);

//======================================================================
// registers
reg [7:0] cs1_ff;
reg [4:0] cs2_ff;
reg low_flag_ff;
reg [6:0] sec_ff;
reg [6:0] min_ff;
reg [5:0] hour_ff;
reg [5:0] day_ff;
reg [2:0] wday_ff;
reg [4:0] mon_ff;
reg cent_ff;
reg [7:0] year_ff;
reg [7:0] alm_ff [0:3];
reg [2:0] clk_ctl_ff;
reg [2:0] tmr_ctl_ff;
reg [7:0] tmr_load_ff;
reg [7:0] tmr_cnt_ff;
reg [14:0] div_ff;
reg pend_ff;
reg chk_ff;
reg tmr_pulse_ff;
reg [1:0] low_sy_ff;
reg int_oe_ff;
reg sq_oe_ff;

wire wr_on = wr_stb;
wire stopped = cs1_ff[`RTCAL_CS1_STOP];
wire sec_tick = osc_rise & ~stopped & (div_ff == 15'h7FFF);
wire step = ~rd_busy & (sec_tick | pend_ff);
wire sec_wrap = (sec_ff == 7'h59);
wire min_wrap = sec_wrap & (min_ff == 7'h59);
wire hour_wrap = min_wrap & (hour_ff == 6'h23);
wire day_wrap = hour_wrap & ({2'b00, day_ff} == month_days(mon_ff, year_ff));
wire mon_wrap = day_wrap & (mon_ff == 5'h12);
wire year_wrap = mon_wrap & (year_ff == 8'h99);
wire [7:0] nxt_sec_bcd = bcd_inc({1'b0, sec_ff});
wire [7:0] nxt_min_bcd = bcd_inc({1'b0, min_ff});
wire [7:0] nxt_hour_bcd = bcd_inc({2'b00, hour_ff});
wire [7:0] nxt_day_bcd = bcd_inc({2'b00, day_ff});
wire [7:0] nxt_mon_bcd = bcd_inc({3'b000, mon_ff});
wire [3:0] alm_idx = ptr - `RTCAL_A_ALM0;

//======================================================================
// prescaler and freeze
always @(posedge core_clk_i or posedge irst) begin
	if (irst) begin
		div_ff <= 15'h0000;
		pend_ff <= 1'b0;
		chk_ff <= 1'b0;
		low_sy_ff <= 2'h0;
	end else begin
		low_sy_ff <= {low_sy_ff[0], supply_low_i};
		if (osc_rise & ~stopped)
			div_ff <= div_ff + 15'h0001;
		if (rd_busy)
			pend_ff <= pend_ff | sec_tick;
		else
			pend_ff <= 1'b0;
		chk_ff <= step & sec_wrap;
	end
end

//======================================================================
// time and calendar counters
always @(posedge core_clk_i or posedge irst) begin
	if (irst) begin
		sec_ff <= `RTCAL_RST_SEC;
		low_flag_ff <= `RTCAL_RST_LOW_FLAG;
		min_ff <= 7'h00;
		hour_ff <= 6'h00;
		day_ff <= `RTCAL_RST_DAY;
		wday_ff <= 3'h0;
		mon_ff <= `RTCAL_RST_MON;
		cent_ff <= 1'b0;
		year_ff <= 8'h00;
	end else begin
		// supply low wins over a software clear
		if (low_sy_ff[1])
			low_flag_ff <= 1'b1;
		else if (wr_on && ptr == `RTCAL_A_SEC)
			low_flag_ff <= wr_data[`RTCAL_TOP];
		if (wr_on && ptr >= `RTCAL_A_SEC && ptr <= `RTCAL_A_YEAR) begin
			case (ptr)
			`RTCAL_A_SEC: sec_ff <= wr_data[6:0];
			`RTCAL_A_MIN: min_ff <= wr_data[6:0];
			`RTCAL_A_HOUR: hour_ff <= wr_data[5:0];
			`RTCAL_A_DAY: day_ff <= wr_data[5:0];
			`RTCAL_A_WDAY: wday_ff <= wr_data[2:0];
			`RTCAL_A_MON: begin
				mon_ff <= wr_data[4:0];
				cent_ff <= wr_data[`RTCAL_TOP];
			end
			default: year_ff <= wr_data;
			endcase
		end else if (step) begin
			sec_ff <= sec_wrap ? 7'h00 : nxt_sec_bcd[6:0];
			if (sec_wrap)
				min_ff <= min_wrap ? 7'h00 : nxt_min_bcd[6:0];
			if (min_wrap)
				hour_ff <= hour_wrap ? 6'h00 : nxt_hour_bcd[5:0];
			if (hour_wrap) begin
				day_ff <= day_wrap ? 6'h01 : nxt_day_bcd[5:0];
				wday_ff <= (wday_ff == 3'h6) ? 3'h0 : wday_ff + 3'h1;
			end
			if (day_wrap)
				mon_ff <= mon_wrap ? 5'h01 : nxt_mon_bcd[4:0];
			if (mon_wrap) begin
				year_ff <= year_wrap ? 8'h00 : bcd_inc(year_ff);
				if (year_wrap)
					cent_ff <= ~cent_ff;
			end
		end
	end
end

//======================================================================
// alarm compare
wire alm_any = ~(alm_ff[0][7] & alm_ff[1][7] & alm_ff[2][7] & alm_ff[3][7]);
wire alm_hit = alm_any & chk_ff &
	(alm_ff[0][7] | (alm_ff[0][6:0] == min_ff)) &
	(alm_ff[1][7] | (alm_ff[1][5:0] == hour_ff)) &
	(alm_ff[2][7] | (alm_ff[2][5:0] == day_ff)) &
	(alm_ff[3][7] | (alm_ff[3][2:0] == wday_ff));

//======================================================================
// countdown timer
reg tmr_src;
always @* begin
	case (tmr_ctl_ff[1:0])
	2'd0: tmr_src = osc_rise & ~stopped & (div_ff[2:0] == 3'h7);
	2'd1: tmr_src = osc_rise & ~stopped & (div_ff[8:0] == 9'h1FF);
	2'd2: tmr_src = sec_tick;
	default: tmr_src = step & sec_wrap;
	endcase
end

wire tmr_end = tmr_ctl_ff[`RTCAL_TOP - 5] & tmr_src & (tmr_cnt_ff <= 8'h01);

//======================================================================
// control, alarm and timer registers
integer i;
always @(posedge core_clk_i or posedge irst) begin
	if (irst) begin
		cs1_ff <= `RTCAL_RST_CS1;
		cs2_ff <= `RTCAL_RST_CS2;
		for (i = 0; i < 4; i = i + 1)
			alm_ff[i] <= `RTCAL_RST_ALM;
		clk_ctl_ff <= `RTCAL_RST_CLK;
		tmr_ctl_ff <= `RTCAL_RST_TCTL;
		tmr_load_ff <= 8'h00;
		tmr_cnt_ff <= 8'h00;
		tmr_pulse_ff <= 1'b0;
	end else begin
		if (wr_on) begin
			case (ptr)
			`RTCAL_A_CS1: cs1_ff <= wr_data & `RTCAL_CS1_MASK;
			`RTCAL_A_CS2: begin
				cs2_ff[`RTCAL_CS2_TIP] <= wr_data[`RTCAL_CS2_TIP];
				cs2_ff[`RTCAL_CS2_AIE] <= wr_data[`RTCAL_CS2_AIE];
				cs2_ff[`RTCAL_CS2_TIE] <= wr_data[`RTCAL_CS2_TIE];
			end
			`RTCAL_A_CLK: clk_ctl_ff <= {wr_data[`RTCAL_TOP], wr_data[1:0]};
			`RTCAL_A_TCTL: tmr_ctl_ff <= {wr_data[`RTCAL_TOP], wr_data[1:0]};
			default: begin
				if (ptr >= `RTCAL_A_ALM0 && ptr <= `RTCAL_A_ALM3)
					alm_ff[alm_idx[1:0]] <= wr_data;
			end
			endcase
		end
		// flags: a hardware set wins over a software clear in the same cycle
		cs2_ff[`RTCAL_CS2_ALM_FLAG] <= alm_hit | (cs2_ff[`RTCAL_CS2_ALM_FLAG] &
			~(wr_on && ptr == `RTCAL_A_CS2 && !wr_data[`RTCAL_CS2_ALM_FLAG]));
		cs2_ff[`RTCAL_CS2_TMR_FLAG] <= tmr_end | (cs2_ff[`RTCAL_CS2_TMR_FLAG] &
			~(wr_on && ptr == `RTCAL_A_CS2 && !wr_data[`RTCAL_CS2_TMR_FLAG]));
		if (wr_on && ptr == `RTCAL_A_TVAL) begin
			tmr_load_ff <= wr_data;
			tmr_cnt_ff <= wr_data;
		end else if (tmr_end) begin
			tmr_cnt_ff <= tmr_load_ff;
		end else if (tmr_ctl_ff[`RTCAL_TOP - 5] & tmr_src) begin
			tmr_cnt_ff <= tmr_cnt_ff - 8'h01;
		end
		if (tmr_end)
			tmr_pulse_ff <= 1'b1;
		else if (osc_rise)
			tmr_pulse_ff <= 1'b0;
	end
end

//======================================================================
// read mux
always @* begin
	case (ptr)
	`RTCAL_A_CS1: rd_data = cs1_ff;
	`RTCAL_A_CS2: rd_data = {3'b000, cs2_ff};
	`RTCAL_A_SEC: rd_data = {low_flag_ff, sec_ff};
	`RTCAL_A_MIN: rd_data = {1'b0, min_ff};
	`RTCAL_A_HOUR: rd_data = {2'b00, hour_ff};
	`RTCAL_A_DAY: rd_data = {2'b00, day_ff};
	`RTCAL_A_WDAY: rd_data = {5'h00, wday_ff};
	`RTCAL_A_MON: rd_data = {cent_ff, 2'b00, mon_ff};
	`RTCAL_A_YEAR: rd_data = year_ff;
	`RTCAL_A_CLK: rd_data = {clk_ctl_ff[2], 5'h00, clk_ctl_ff[1:0]};
	`RTCAL_A_TCTL: rd_data = {tmr_ctl_ff[2], 5'h00, tmr_ctl_ff[1:0]};
	`RTCAL_A_TVAL: rd_data = tmr_cnt_ff;
	default: rd_data = alm_ff[alm_idx[1:0]];
	endcase
end

//======================================================================
// interrupt and square wave pins
reg sq_level;
always @* begin
	case (clk_ctl_ff[1:0])
	2'd0: sq_level = osc_s;
	2'd1: sq_level = div_ff[4];
	2'd2: sq_level = div_ff[9];
	default: sq_level = div_ff[14];
	endcase
end

always @(posedge core_clk_i or posedge irst) begin
	if (irst) begin
		int_oe_ff <= 1'b0;
		sq_oe_ff <= 1'b0;
	end else begin
		int_oe_ff <= (cs2_ff[`RTCAL_CS2_AIE] & cs2_ff[`RTCAL_CS2_ALM_FLAG]) |
			(cs2_ff[`RTCAL_CS2_TIE] & (cs2_ff[`RTCAL_CS2_TIP] ? tmr_pulse_ff :
			cs2_ff[`RTCAL_CS2_TMR_FLAG]));
		sq_oe_ff <= clk_ctl_ff[2] & ~sq_level;
	end
end

assign int_n_o = 1'b0;
assign int_n_oe_o = int_oe_ff;
assign square_wave_out_o = 1'b0;
assign square_wave_out_oe_o = sq_oe_ff;

endmodule // rtcal_top
`default_nettype wire

/* dv/rtcal_checker.sv */
// pin-level assertions for rtcal_top
`timescale 1ns/10ps
`default_nettype none
module rtcal_checker #(
	parameter [19:0] OSC_STOP_CYC = 20'd200
) (
	// clock, reset and inputs
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic osc_i,
	input wire logic supply_low_i,
	input wire logic scl_i,
	input wire logic sda_i,
	// outputs
	input wire logic sda_o,
	input wire logic sda_oe_o,
	input wire logic int_n_o,
	input wire logic int_n_oe_o,
	input wire logic square_wave_out_o,
	input wire logic square_wave_out_oe_o
);
	//========
	// helpers
	logic [20:0] still_ff;
	logic [7:0] osc_hist_ff;
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			still_ff <= 21'h0;
			osc_hist_ff <= 8'h00;
		end else begin
			still_ff <= (osc_i != osc_hist_ff[0]) ? 21'h0 : still_ff + 21'h1;
			osc_hist_ff <= {osc_hist_ff[6:0], osc_i};
		end
	end
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	//========
	// properties
	property p_int_od; !int_n_o; endproperty
	a_int_od: assert property (p_int_od) else $error("int pin driven high");
	property p_sq_od; !square_wave_out_o; endproperty
	a_sq_od: assert property (p_sq_od) else $error("square pin driven high");
	property p_sda_od; !sda_o; endproperty
	a_sda_od: assert property (p_sda_od) else $error("data pin driven high");
	property p_rst_quiet;
		$fell(rst_i) |-> !(sda_oe_o | int_n_oe_o | square_wave_out_oe_o) [*2];
	endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("pin active at reset exit");
	property p_osc_stop;
		still_ff > OSC_STOP_CYC + 8 |-> !(sda_oe_o | int_n_oe_o | square_wave_out_oe_o);
	endproperty
	a_osc_stop: assert property (p_osc_stop) else $error("pin active with osc stopped");
	property p_sda_stand; scl_i && $past(scl_i) |-> $stable(sda_oe_o); endproperty
	a_sda_stand: assert property (p_sda_stand) else $error("data moved with clock high");
	property p_sda_rise; $rose(sda_oe_o) |-> $past(scl_i, 2) == 1'b0; endproperty
	a_sda_rise: assert property (p_sda_rise) else $error("data pulled outside low phase");
	property p_sq_osc;
		// a stopped oscillator resets the pin without any edge of its own
		$changed(square_wave_out_oe_o) && scl_i && $past(scl_i) && still_ff < OSC_STOP_CYC / 2
			|-> osc_hist_ff != 8'h00 && osc_hist_ff != 8'hFF;
	endproperty
	a_sq_osc: assert property (p_sq_osc) else $error("square edge without osc edge");
	c_ack: cover property ($rose(sda_oe_o));
	c_int: cover property ($rose(int_n_oe_o));
	c_stop: cover property (still_ff > OSC_STOP_CYC + 8);
endmodule // rtcal_checker
`default_nettype wire

/* dv/rtcal_i2c_master.sv */
// serial bus master model: drives the clock, pulls the data wire low
`timescale 1ns/10ps
`default_nettype none
module rtcal_i2c_master (
	// clock
	input wire logic core_clk_i,
	// serial bus
	input wire logic sda_i,
	output var logic scl_o,
	output var logic sda_pull_o
);
	localparam int HALF = 20;
	initial begin
		scl_o = 1'b1;
		sda_pull_o = 1'b0;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge core_clk_i);
	endtask
	// data moves mid low phase, sampled at end of high phase
	task automatic send_bit(input logic b, output logic seen);
		wt(HALF / 2);
		sda_pull_o <= ~b;
		wt(HALF / 2);
		scl_o <= 1'b1;
		wt(HALF);
		seen = sda_i;
		scl_o <= 1'b0;
	endtask
	task automatic start();
		wt(HALF / 2);
		sda_pull_o <= 1'b0;
		wt(HALF / 2);
		scl_o <= 1'b1;
		wt(HALF);
		sda_pull_o <= 1'b1;
		wt(HALF);
		scl_o <= 1'b0;
	endtask
	task automatic stop();
		wt(HALF / 2);
		sda_pull_o <= 1'b1;
		wt(HALF / 2);
		scl_o <= 1'b1;
		wt(HALF);
		sda_pull_o <= 1'b0;
		wt(HALF);
	endtask
	task automatic put_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) send_bit(d[i], s);
		send_bit(1'b1, s);
		ack = ~s;
	endtask
	// last byte of a read is refused so the device lets go
	task automatic get_byte(input logic last, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			send_bit(1'b1, s);
			d[i] = s;
		end
		send_bit(last, s);
	endtask
endmodule // rtcal_i2c_master
`default_nettype wire

/* dv/rtcal_top_tb_top.sv */
// self-checking bench for rtcal_top
`timescale 1ns/10ps
`default_nettype none
`include "rtcal_consts.vh"
module rtcal_top_tb_top;
	localparam int LIMIT = 90000;
	logic core_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic osc_i = 1'b0;
	logic osc_run = 1'b1;
	logic supply_low_i = 1'b0;
	logic scl_w, pull_w, sda_oe_w, int_oe_w, sq_oe_w, sda_o_w, int_w, sq_w, ack;
	wire logic sda_w = ~(pull_w | sda_oe_w);
	int fails = 0;
	int comparisons = 0;
	int cyc = 0;
	int edges;
	int pulses;
	logic [7:0] rb [16];
	logic [7:0] rst_exp [16] = '{8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01,
		8'h00, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h03, 8'h00};
	logic [23:0] rows [11] = '{24'h035959, 24'h042323, 24'h053131, 24'h060606,
		24'h079292, 24'h089999, 24'h094545, 24'h0C8686, 24'h00FFA8, 24'h000000, 24'h020000};
	rtcal_top #(.OSC_STOP_CYC(20'd200)) u_rtcal_top (
		.core_clk_i(core_clk_i), .rst_i(rst_i), .osc_i(osc_i), .supply_low_i(supply_low_i),
		.scl_i(scl_w), .sda_i(sda_w), .sda_o(sda_o_w), .sda_oe_o(sda_oe_w),
		.int_n_o(int_w), .int_n_oe_o(int_oe_w),
		.square_wave_out_o(sq_w), .square_wave_out_oe_o(sq_oe_w));
	rtcal_i2c_master u_rtcal_i2c_master (
		.core_clk_i(core_clk_i), .sda_i(sda_w), .scl_o(scl_w), .sda_pull_o(pull_w));
	always #2 core_clk_i = ~core_clk_i;
	int osc_cnt = 0;
	always @(posedge core_clk_i) begin
		osc_cnt <= (osc_cnt == 19) ? 0 : osc_cnt + 1;
		if (osc_cnt == 19 && osc_run)
			osc_i <= ~osc_i;
	end
	always @(posedge core_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			fails++;
			tally_and_finish();
		end
	end
	//========
	// tasks
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		if (fails == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge core_clk_i);
	endtask
	task automatic xb(input logic [7:0] d);
		logic a;
		u_rtcal_i2c_master.put_byte(d, a);
		chk("ack", {7'h00, a}, 8'h01);
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		u_rtcal_i2c_master.start();
		xb(`RTCAL_DEV_WR);
		xb({4'h0, a});
		xb(d);
		u_rtcal_i2c_master.stop();
	endtask
	task automatic rd(input logic [3:0] a, input int n);
		u_rtcal_i2c_master.start();
		xb(`RTCAL_DEV_WR);
		xb({4'h0, a});
		u_rtcal_i2c_master.start();
		xb(`RTCAL_DEV_RD);
		for (int i = 0; i < n; i++) u_rtcal_i2c_master.get_byte(i == n - 1, rb[i]);
		u_rtcal_i2c_master.stop();
	endtask
	task automatic count_edges(input int n);
		logic last;
		edges = 0;
		@(negedge core_clk_i);
		last = sq_oe_w;
		repeat (n) begin
			@(negedge core_clk_i);
			edges += (sq_oe_w != last);
			last = sq_oe_w;
		end
	endtask
	//========
	// sequence
	initial begin
		wt(3);
		rst_i <= 1'b0;
		wt(200);
		rd(4'h0, 16);
		for (int i = 0; i < 16; i++) chk("reset value", rb[i], rst_exp[i]);
		for (int i = 0; i < 11; i++) begin
			wr(rows[i][19:16], rows[i][15:8]);
			rd(rows[i][19:16], 1);
			chk("readback", rb[0], rows[i][7:0]);
		end
		rd(4'hF, 2);
		chk("pointer wrap", rb[1], 8'h00);
		u_rtcal_i2c_master.start();
		u_rtcal_i2c_master.put_byte(8'hA0, ack);
		chk("foreign address", {7'h00, ack}, 8'h00);
		u_rtcal_i2c_master.stop();
		supply_low_i <= 1'b1;
		wt(10);
		supply_low_i <= 1'b0;
		rd(4'h2, 1);
		chk("supply low", rb[0], 8'h80);
		wr(4'hF, 8'hFF);
		wr(4'hE, 8'h80);
		wt(1000);
		rd(4'hF, 1);
		chk("live count", {7'h00, rb[0] < 8'hFF}, 8'h01);
		wr(4'hF, 8'h02);
		wt(1500);
		rd(4'h1, 1);
		chk("timer flag", rb[0], 8'h04);
		wr(4'hE, 8'h03);
		wr(4'h1, 8'h05);
		chk("int level", {7'h00, int_oe_w}, 8'h01);
		wr(4'h1, 8'h01);
		chk("int cleared", {7'h00, int_oe_w}, 8'h00);
		rd(4'h1, 1);
		chk("flag cleared", rb[0], 8'h01);
		wr(4'h1, 8'h11);
		wr(4'hE, 8'h80);
		pulses = 0;
		repeat (1200) begin
			@(negedge core_clk_i);
			pulses += int_oe_w;
		end
		chk("int pulse", {7'h00, pulses > 0 && pulses < 100}, 8'h01);
		rd(4'h1, 1);
		chk("pulse mode flag", rb[0], 8'h15);
		wr(4'hD, 8'h00);
		count_edges(400);
		chk("square off", edges[7:0], 8'h00);
		wr(4'hD, 8'h80);
		count_edges(400);
		chk("square osc", edges[7:0], 8'h14);
		wr(4'hD, 8'h81);
		count_edges(2560);
		chk("square 1024", edges[7:0], 8'h04);
		@(posedge osc_i);
		osc_run = 1'b0;
		wt(400);
		osc_run = 1'b1;
		wt(200);
		rd(4'h8, 6);
		chk("year after stop", rb[0], 8'h00);
		chk("square ctl after stop", rb[5], 8'h80);
		tally_and_finish();
	end
endmodule // rtcal_top_tb_top
bind rtcal_top rtcal_checker #(.OSC_STOP_CYC(OSC_STOP_CYC)) u_rtcal_checker (
	.core_clk_i(core_clk_i), .rst_i(rst_i), .osc_i(osc_i), .supply_low_i(supply_low_i),
	.scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
	.int_n_o(int_n_o), .int_n_oe_o(int_n_oe_o), .square_wave_out_o(square_wave_out_o),
	.square_wave_out_oe_o(square_wave_out_oe_o));
`default_nettype wire
